// ---- adcp_host_model.sv ----
// Purpose: host serial controller model facing the converter port
// Assumes: clk is the 50 MHz bench clock, pins change at its falling edge
// Notes:   serial clock idles high and runs only inside frames
`timescale 1ns/100ps
`default_nettype none

module adcp_host_model
(
    input  wire logic clk,
    input  wire logic line_a,
    input  wire logic line_b,
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi,
    output logic      cal
);
    logic in_frame = 1'b0;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi  = 1'b0;
        cal  = 1'b0;
    end

    // data in wanders between frames so a stale bit never looks valid
    always @(negedge clk)
        if (!in_frame)
            sdi <= (sdi !== 1'b1);

    // eight clk per serial period: 6.25 MHz, inside the allowed band
    task automatic frame(input int nfall, input logic [18:0] word,
                         output logic [18:0] cap_a, output logic [18:0] cap_b);
        cap_a = 19'h00000;
        cap_b = 19'h00000;
        @(negedge clk);
        in_frame = 1'b1;
        cs_n     = 1'b0;
        repeat (8) @(negedge clk);
        for (int k = 0; k < nfall; k++)
        begin
            sdi = word[18-k];
            repeat (4) @(negedge clk);
            cap_a[18-k] = line_a;
            cap_b[18-k] = line_b;
            sclk = 1'b0;
            repeat (4) @(negedge clk);
            sclk = 1'b1;
        end
        repeat (6) @(negedge clk);
    endtask

    task automatic end_frame();
        @(negedge clk);
        cs_n     = 1'b1;
        in_frame = 1'b0;
        repeat (6) @(negedge clk);
    endtask

    task automatic cal_pulse(input int len);
        @(negedge clk);
        cal = 1'b1;
        repeat (len) @(negedge clk);
        cal = 1'b0;
        repeat (100) @(negedge clk);
    endtask
endmodule

`default_nettype wire

// ---- adcp_pkg.sv ----
// Purpose: types shared by the dual converter serial port
// Assumes: adcp_regs.svh supplies the widths
// Notes:   one sample carries both simultaneously taken channels
`include "adcp_regs.svh"

package adcp_pkg;

    typedef struct packed
    {
        logic [`ADCP_DATA_BITS-1:0] chan_first;
        logic [`ADCP_DATA_BITS-1:0] chan_second;
    } adcp_sample_t;

    typedef enum logic [1:0]
    {
        ADCP_IDLE  = 2'b00,
        ADCP_SHIFT = 2'b01,
        ADCP_DONE  = 2'b10
    } adcp_state_t;

endpackage

// ---- adcp_regs.svh ----
// Purpose: timing counts and field sizes of the dual converter serial port
// Assumes: system clock at 50 MHz
// Notes:   times are kept in their own unit; cycle counts derive from them
`ifndef ADCP_REGS_SVH
`define ADCP_REGS_SVH

// ----------------------------------------------------------------------
// clock and frame
// ----------------------------------------------------------------------
`define ADCP_CLK_MHZ            50
`define ADCP_DATA_BITS          14
`define ADCP_CONVERSION_DURATION_SCLKS 5'h13
`define ADCP_CMD_BITS           19

// ----------------------------------------------------------------------
// calibration and power-up waits
// ----------------------------------------------------------------------
`define ADCP_CAL_MIN_US         2
`define ADCP_CAL_MIN_CYC        (`ADCP_CAL_MIN_US * `ADCP_CLK_MHZ)
`define ADCP_PWRUP_INT_US       240
`define ADCP_PWRUP_INT_CYC      (`ADCP_PWRUP_INT_US * `ADCP_CLK_MHZ)
`define ADCP_PWRUP_EXT_US       15
`define ADCP_PWRUP_EXT_CYC      (`ADCP_PWRUP_EXT_US * `ADCP_CLK_MHZ)

// ----------------------------------------------------------------------
// buffer
// ----------------------------------------------------------------------
`define ADCP_BUF_DEPTH          2

`endif

// ---- adcp_serial_port.sv ----
// Purpose: serial conversion and readout port, device end
// Assumes: pins are asynchronous to clk and are synchronised here;
//          the serial clock stays well below clk / 4
// Notes:   results leave msb first, zeros after the data bits
`timescale 1ns/100ps
`default_nettype none

module adcp_serial_port
    import adcp_pkg::*;
#(
    parameter int unsigned PWRUP_INT_CYCLES = `ADCP_PWRUP_INT_CYC
)
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  cs_n,
    input  wire logic                  sclk,
    input  wire logic                  sdi,
    input  wire logic                  cal,
    input  wire logic                  ext_ref,
    input  wire adcp_sample_t          sample_in,
    input  wire logic                  sample_valid,
    output logic                       sample_ready,
    output logic                       serial_out_first,
    output logic                       serial_out_first_oe,
    output logic                       serial_out_second,
    output logic                       serial_out_second_oe,
    output logic                       conv_start,
    output logic                       conv_busy,
    output logic [`ADCP_CMD_BITS-1:0]  cmd_word,
    output logic                       cmd_valid,
    output logic                       cal_start,
    output logic                       ref_settled
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic       cs_prev;
    logic       sclk_prev;
    wire logic  cs_s      = sync2[0];
    wire logic  sclk_s    = sync2[1];
    wire logic  sdi_s     = sync2[2];
    wire logic  cal_s     = sync2[3];
    wire logic  ext_s     = sync2[4];
    wire logic  cs_fall   = cs_prev & ~cs_s;
    wire logic  cs_rise   = ~cs_prev & cs_s;
    wire logic  sclk_fall = sclk_prev & ~sclk_s;

    // edge detectors read the second stage only, never the first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1     <= 5'h1F;
            sync2     <= 5'h1F;
            cs_prev   <= 1'b1;
            sclk_prev <= 1'b1;
        end
        else
        begin
            sync1     <= {ext_ref, cal, sdi, sclk, cs_n};
            sync2     <= sync1;
            cs_prev   <= cs_s;
            sclk_prev <= sclk_s;
        end
    end

    // ------------------------------------------------------------------
    // two-entry sample buffer
    // ------------------------------------------------------------------
    adcp_sample_t buf_mem [`ADCP_BUF_DEPTH];
    logic         wr_ptr;
    logic         rd_ptr;
    logic [1:0]   buf_count;
    adcp_state_t  state;
    wire logic do_push = sample_valid & sample_ready;
    // a frame that finds the buffer empty reads out zeros
    wire logic do_pop  = cs_fall & (state != ADCP_SHIFT) & (buf_count != 2'h0);
    wire logic [1:0] next_count = buf_count + 2'(do_push) - 2'(do_pop);
    wire adcp_sample_t head = buf_mem[rd_ptr];

    always_ff @(posedge clk)
    begin
        if (do_push)
            buf_mem[wr_ptr] <= sample_in;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr       <= 1'b0;
            rd_ptr       <= 1'b0;
            buf_count    <= 2'h0;
            sample_ready <= 1'b1;
        end
        else
        begin
            if (do_push)
                wr_ptr <= ~wr_ptr;
            if (do_pop)
                rd_ptr <= ~rd_ptr;
            buf_count    <= next_count;
            sample_ready <= (next_count != 2'h2);
        end
    end

    // ------------------------------------------------------------------
    // frame sequencing
    // ------------------------------------------------------------------
    logic [4:0]                 fall_cnt;
    logic [`ADCP_DATA_BITS-1:0] shift_first;
    logic [`ADCP_DATA_BITS-1:0] shift_second;
    logic [`ADCP_CMD_BITS-1:0]  cmd_shift;
    wire logic last_fall = (fall_cnt == `ADCP_CONVERSION_DURATION_SCLKS - 5'h1);
    wire logic shift_fall = (state == ADCP_SHIFT) & sclk_fall & ~cs_rise;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= ADCP_IDLE;
            fall_cnt <= 5'h00;
        end
        else if (cs_rise)
        begin
            state    <= ADCP_IDLE;
            fall_cnt <= 5'h00;
        end
        else if (cs_fall && state != ADCP_SHIFT)
        begin
            state    <= ADCP_SHIFT;
            fall_cnt <= 5'h00;
        end
        else if (state == ADCP_SHIFT && sclk_fall)
        begin
            fall_cnt <= fall_cnt + 5'h01;
            if (last_fall)
                state <= ADCP_DONE;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_start <= 1'b0;
            conv_busy  <= 1'b0;
        end
        else
        begin
            conv_start <= cs_fall & (state != ADCP_SHIFT) & ~cs_rise;
            if (cs_rise || (state == ADCP_SHIFT && sclk_fall && last_fall))
                conv_busy <= 1'b0;
            else if (cs_fall && state != ADCP_SHIFT)
                conv_busy <= 1'b1;
        end
    end
    // data outputs: loaded when chip select falls, shifted on falling sclk
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_first          <= '0;
            shift_second         <= '0;
            serial_out_first     <= 1'b0;
            serial_out_second    <= 1'b0;
            serial_out_first_oe  <= 1'b0;
            serial_out_second_oe <= 1'b0;
        end
        else if (cs_rise)
        begin
            serial_out_first_oe  <= 1'b0;
            serial_out_second_oe <= 1'b0;
        end
        else if (cs_fall && state != ADCP_SHIFT)
        begin
            serial_out_first     <= do_pop & head.chan_first[13];
            serial_out_second    <= do_pop & head.chan_second[13];
            shift_first  <= do_pop ? {head.chan_first[12:0], 1'b0} : '0;
            shift_second <= do_pop ? {head.chan_second[12:0], 1'b0} : '0;
            serial_out_first_oe  <= 1'b1;
            serial_out_second_oe <= 1'b1;
        end
        else if (state == ADCP_SHIFT && sclk_fall)
        begin
            serial_out_first  <= shift_first[`ADCP_DATA_BITS-1];
            serial_out_second <= shift_second[`ADCP_DATA_BITS-1];
            shift_first       <= {shift_first[12:0], 1'b0};
            shift_second      <= {shift_second[12:0], 1'b0};
            if (last_fall)
            begin
                serial_out_first_oe  <= 1'b0;
                serial_out_second_oe <= 1'b0;
            end
        end
    end
    // serial input word, handed on after the full frame only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_shift <= '0;
            cmd_word  <= '0;
            cmd_valid <= 1'b0;
        end
        else
        begin
            cmd_valid <= shift_fall & last_fall;
            if (shift_fall)
                cmd_shift <= {cmd_shift[17:0], sdi_s};
            if (shift_fall && last_fall)
                cmd_word  <= {cmd_shift[17:0], sdi_s};
        end
    end

    // ------------------------------------------------------------------
    // calibration request and power-up settling
    // ------------------------------------------------------------------
    logic [7:0]  cal_cnt;
    logic [13:0] pwr_cnt;
    wire logic [13:0] pwr_limit = ext_s ? 14'(`ADCP_PWRUP_EXT_CYC)
                                        : 14'(PWRUP_INT_CYCLES);
    // a pulse shorter than the minimum is ignored rather than half-acted on
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_cnt   <= 8'h00;
            cal_start <= 1'b0;
        end
        else
        begin
            cal_start <= cal_s & (cal_cnt == 8'(`ADCP_CAL_MIN_CYC - 1));
            if (!cal_s)
                cal_cnt <= 8'h00;
            else if (cal_cnt != 8'(`ADCP_CAL_MIN_CYC))
                cal_cnt <= cal_cnt + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_cnt     <= 14'h0000;
            ref_settled <= 1'b0;
        end
        else if (pwr_cnt < pwr_limit)
            pwr_cnt <= pwr_cnt + 14'h0001;
        else
            ref_settled <= 1'b1;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence frame_open;
        cs_fall && state != ADCP_SHIFT && !cs_rise;
    endsequence
    chk_frame_start_drive: assert property (
        frame_open |=> conv_start && conv_busy && serial_out_first_oe
                       && serial_out_second_oe)
        else $error("frame start did not drive outputs");
    chk_last_edge_float: assert property (
        state == ADCP_SHIFT && sclk_fall && last_fall && !cs_rise
        |=> !serial_out_first_oe && !serial_out_second_oe
            && state == ADCP_DONE)
        else $error("outputs not floated after last edge");
    chk_conv_length: assert property (
        state == ADCP_SHIFT && sclk_fall && !cs_rise
        |=> conv_busy == (fall_cnt != `ADCP_CONVERSION_DURATION_SCLKS))
        else $error("conversion length wrong");
    chk_cs_rise_float: assert property (
        cs_rise |=> !serial_out_first_oe && !serial_out_second_oe
                    && !conv_busy)
        else $error("chip select rise did not float outputs");
    chk_input_sample: assert property (
        state == ADCP_SHIFT && sclk_fall && !cs_rise
        |=> cmd_shift[0] == $past(sdi_s))
        else $error("serial input not sampled on falling edge");
    chk_output_timing: assert property (
        $changed(serial_out_first) || $changed(serial_out_second)
        |-> $past(sclk_fall) || $past(cs_fall))
        else $error("output bit changed without a falling edge");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench of the converter serial port
// Assumes: short power-up wait through PWRUP_INT_CYCLES
// Notes:   released data lines show a pattern that moves every cycle
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import adcp_pkg::*;

    logic         clk, rst_n, ext_ref, sample_valid, sample_ready;
    adcp_sample_t sample_in, exp_s;
    logic         out_a, oe_a, out_b, oe_b, flip;
    logic         conv_start, conv_busy, cmd_valid, cal_start, ref_settled;
    logic [18:0]  cmd_word, cap_a, cap_b, word;
    logic         cs_n, sclk, sdi, cal;
    wire          line_a, line_b;
    int           mismatches = 0;
    int           check_count = 0;
    int           seed = 4838;
    int           n_start = 0;
    int           n_cmd = 0;
    int           n_cal = 0;
    adcp_sample_t expq[$];

    assign line_a = oe_a ? out_a : flip;
    assign line_b = oe_b ? out_b : flip;

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        flip <= (flip === 1'b1) ? 1'b0 : 1'b1;
        n_start <= n_start + int'(conv_start === 1'b1);
        n_cmd <= n_cmd + int'(cmd_valid === 1'b1);
        n_cal <= n_cal + int'(cal_start === 1'b1);
    end

    adcp_serial_port #(.PWRUP_INT_CYCLES(20)) dut
    (
        .clk                  (clk),
        .rst_n                (rst_n),
        .cs_n                 (cs_n),
        .sclk                 (sclk),
        .sdi                  (sdi),
        .cal                  (cal),
        .ext_ref              (ext_ref),
        .sample_in            (sample_in),
        .sample_valid         (sample_valid),
        .sample_ready         (sample_ready),
        .serial_out_first     (out_a),
        .serial_out_first_oe  (oe_a),
        .serial_out_second    (out_b),
        .serial_out_second_oe (oe_b),
        .conv_start           (conv_start),
        .conv_busy            (conv_busy),
        .cmd_word             (cmd_word),
        .cmd_valid            (cmd_valid),
        .cal_start            (cal_start),
        .ref_settled          (ref_settled)
    );

    adcp_host_model host
    (
        .clk    (clk),
        .line_a (line_a),
        .line_b (line_b),
        .cs_n   (cs_n),
        .sclk   (sclk),
        .sdi    (sdi),
        .cal    (cal)
    );

    function automatic logic [18:0] exp_line(adcp_sample_t s, logic first);
        return first ? {s.chan_first, 5'h00} : {s.chan_second, 5'h00};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // the source holds its word for at most 20 cycles while it waits for room in the buffer
    task automatic push();
        @(negedge clk);
        sample_in    = 28'($random(seed));
        sample_valid = 1'b1;
        for (int i = 0; i < 20 && sample_ready !== 1'b1; i++)
            @(negedge clk);
        if (sample_ready !== 1'b1)
            mismatches++;
        @(posedge clk);
        expq.push_back(sample_in);
        @(negedge clk);
        sample_valid = 1'b0;
    endtask

    task automatic run_frame(input int nfall, input logic has_data);
        word  = 19'($random(seed));
        exp_s = has_data ? expq.pop_front() : 28'h0000000;
        host.frame(nfall, word, cap_a, cap_b);
        check(cap_a, exp_line(exp_s, 1'b1));
        check(cap_b, exp_line(exp_s, 1'b0));
        check(oe_a | oe_b, nfall < 19);
        check(conv_busy, nfall < 19);
        if (nfall == 19)
            check(cmd_word, word);
        host.end_frame();
        check(oe_a | oe_b, 1'b0);
    endtask

    initial
    begin
        rst_n        = 1'b0;
        ext_ref      = 1'b0;
        sample_in    = 28'h0000000;
        sample_valid = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        check(sample_ready, 1'b1);
        repeat (40) @(negedge clk);
        check(ref_settled, 1'b1);
        push();
        push();
        repeat (2) @(negedge clk);
        check(sample_ready, 1'b0);
        run_frame(18, 1'b1);
        run_frame(19, 1'b1);
        run_frame(19, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            push();
            run_frame(19, 1'b1);
        end
        host.cal_pulse(50);
        check(n_cal, 0);
        host.cal_pulse(120);
        check(n_cal, 1);
        check(n_start, 9);
        check(n_cmd, 8);
        // mid-run reset with the external reference strapped
        @(negedge clk);
        rst_n   = 1'b0;
        ext_ref = 1'b1;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        check(sample_ready, 1'b1);
        check(oe_a | oe_b, 1'b0);
        repeat (700) @(negedge clk);
        check(ref_settled, 1'b0);
        repeat (60) @(negedge clk);
        check(ref_settled, 1'b1);
        push();
        run_frame(19, 1'b1);
        print_verdict();
    end

    // the whole sequence needs about 3000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule

`default_nettype wire
